// ### src/key_wake_unit.sv
// key wake unit: eight key pins, edge or edge-plus-level detection,
// one key request, wake request, apb register file and a masked interrupt
// assumes clk is the always-on clock that still runs in stop3 and that
// power_mode comes from logic on the same clock
//
// The implementer's own choices: the register offsets and register access over APB.
`timescale 1ns/1ps

// Summary of operation
// - eight key pins, each counted only when its own enable bit is set
// - edge only or edge plus level for all pins together; per pin polarity low/falling or high/rising
// - enabled pins merge into one request, gated by the key interrupt enable
// - detection keeps running in wait mode when enabled beforehand
// - in wait mode an enabled pin event wakes the processor if enabled
// - in stop3 detection continues without bus clock activity
// - in stop3 an enabled pin event wakes the processor if enabled
// - in stop1 and stop2 the unit detects nothing
// - after stop1 or stop2 all five registers, the event flag and the edge detector are at reset value; the pin synchroniser keeps sampling
// - in background debug mode the unit behaves exactly as in run mode
// - five registers: status/control, pin enables, edge select, interrupt status, interrupt mask
// - status/control holds event flag, interrupt enable and detection mode
module key_wake_unit
    import key_wake_pkg::*;
(
    // clock, reset, enable
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    // system power mode
    input wire key_wake_pkg::power_mode_t power_mode,
    // key pins
    input wire logic [key_wake_pkg::KEY_PINS-1:0] key_input_pin,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [key_wake_pkg::APB_ADDR_W-1:0] paddr,
    input wire logic [key_wake_pkg::APB_DATA_W-1:0] pwdata,
    output logic [key_wake_pkg::APB_DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    // requests
    output logic key_request,
    output logic wake_request,
    output logic irq
);

    import key_wake_pkg::*;

    // ***********************
    // helpers
    // ***********************
    // a set polarity bit selects rising edge / high level
    function automatic logic [KEY_PINS-1:0] active_level(
        input logic [KEY_PINS-1:0] pins,
        input logic [KEY_PINS-1:0] pol
    );
        active_level = ~(pins ^ pol);
    endfunction

    function automatic logic addr_is(
        input logic [APB_ADDR_W-1:0] addr,
        input logic [APB_ADDR_W-1:0] ofs
    );
        addr_is = (addr == ofs);
    endfunction

    // ***********************
    // declarations
    // ***********************
    logic [KEY_PINS-1:0] pin_sync1;
    logic [KEY_PINS-1:0] pin_sync2;
    logic [KEY_PINS-1:0] active_prev;
    logic [KEY_PINS-1:0] active_now;
    logic [KEY_PINS-1:0] edge_hit;
    logic [KEY_PINS-1:0] level_hit;
    logic [7:0] pin_detect_enable;
    logic [7:0] edge_select;
    logic level_mode;
    logic key_irq_enable;
    logic event_flag;
    logic [IRQ_BITS-1:0] irq_status;
    logic [IRQ_BITS-1:0] irq_mask;
    logic [IRQ_BITS-1:0] irq_set;
    logic [IRQ_BITS-1:0] irq_clr;
    logic [IRQ_BITS-1:0] next_irq_status;
    logic deep_stop;
    logic wake_mode;
    logic detect_on;
    logic key_hit;
    logic access;
    logic wr_fire;
    logic rd_fire;
    logic ack_write;
    logic [APB_DATA_W-1:0] rd_word;
    logic rd_err;

    // ***********************
    // mode decode
    // ***********************
    // stop1/stop2 power the unit down: registers are held at reset while there
    assign deep_stop = (power_mode == MODE_STOP1) || (power_mode == MODE_STOP2);
    // run, wait, stop3 and debug all detect; stop3 runs off the always-on clock
    assign detect_on = !deep_stop;
    assign wake_mode = (power_mode == MODE_WAIT) || (power_mode == MODE_STOP3);

    // ***********************
    // pin synchroniser and detection
    // ***********************
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pin_sync1 <= 8'h00;
            pin_sync2 <= 8'h00;
        end
        else if (ce)
        begin
            pin_sync1 <= key_input_pin;
            pin_sync2 <= pin_sync1;
        end
    end

    assign active_now = active_level(pin_sync2, edge_select);

    // prev is forced active while powered down so a pin held active is
    // not mistaken for a fresh edge on the way out of stop1 or stop2
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            active_prev <= 8'hFF;
        end
        else if (ce)
        begin
            if (deep_stop)
            begin
                active_prev <= 8'hFF;
            end
            else
            begin
                active_prev <= active_now;
            end
        end
    end

    assign edge_hit = active_now & ~active_prev & pin_detect_enable;
    assign level_hit = active_now & pin_detect_enable & {KEY_PINS{level_mode}};
    assign key_hit = detect_on && ((|edge_hit) || (|level_hit));

    // ***********************
    // apb decode
    // ***********************
    assign access = psel && penable;
    assign wr_fire = access && pready && pwrite;
    assign rd_fire = access && pready && !pwrite;
    assign ack_write = wr_fire && addr_is(paddr, OFS_STATUS_CTRL) && pwdata[SC_ACK];

    always_comb
    begin
        rd_word = 32'h0000_0000;
        rd_err = 1'b0;
        if (addr_is(paddr, OFS_STATUS_CTRL))
        begin
            rd_word[SC_FLAG] = event_flag;
            rd_word[SC_IRQ_ENABLE] = key_irq_enable;
            rd_word[SC_LEVEL_MODE] = level_mode;
        end
        else if (addr_is(paddr, OFS_PIN_ENABLE))
        begin
            rd_word[7:0] = pin_detect_enable;
        end
        else if (addr_is(paddr, OFS_EDGE_SELECT))
        begin
            rd_word[7:0] = edge_select;
        end
        else if (addr_is(paddr, OFS_IRQ_STATUS))
        begin
            rd_word[IRQ_BITS-1:0] = irq_status;
        end
        else if (addr_is(paddr, OFS_IRQ_MASK))
        begin
            rd_word[IRQ_BITS-1:0] = irq_mask;
        end
        else
        begin
            rd_err = 1'b1;
        end
    end

    // one wait state: pready rises in the second access cycle
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end
        else if (ce)
        begin
            pready <= access && !pready;
            pslverr <= access && !pready && rd_err;
            if (access && !pready && !pwrite)
            begin
                prdata <= rd_word;
            end
        end
    end

    // ***********************
    // configuration registers
    // ***********************
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pin_detect_enable <= RST_PIN_ENABLE;
            edge_select <= RST_EDGE_SELECT;
            level_mode <= 1'b0;
            key_irq_enable <= 1'b0;
            irq_mask <= RST_IRQ_MASK;
        end
        else if (ce)
        begin
            if (deep_stop)
            begin
                pin_detect_enable <= RST_PIN_ENABLE;
                edge_select <= RST_EDGE_SELECT;
                level_mode <= 1'b0;
                key_irq_enable <= 1'b0;
                irq_mask <= RST_IRQ_MASK;
            end
            else if (wr_fire)
            begin
                if (addr_is(paddr, OFS_STATUS_CTRL))
                begin
                    level_mode <= pwdata[SC_LEVEL_MODE];
                    key_irq_enable <= pwdata[SC_IRQ_ENABLE];
                end
                else if (addr_is(paddr, OFS_PIN_ENABLE))
                begin
                    pin_detect_enable <= pwdata[7:0];
                end
                else if (addr_is(paddr, OFS_EDGE_SELECT))
                begin
                    edge_select <= pwdata[7:0];
                end
                else if (addr_is(paddr, OFS_IRQ_MASK))
                begin
                    irq_mask <= pwdata[IRQ_BITS-1:0];
                end
            end
        end
    end

    // ***********************
    // key event flag
    // ***********************
    // a hit in the acknowledge cycle wins, so a held level re-sets at once
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            event_flag <= 1'b0;
        end
        else if (ce)
        begin
            if (deep_stop)
            begin
                event_flag <= 1'b0;
            end
            else if (key_hit)
            begin
                event_flag <= 1'b1;
            end
            else if (ack_write)
            begin
                event_flag <= 1'b0;
            end
        end
    end

    // ***********************
    // sticky interrupt status
    // ***********************
    always_comb
    begin
        irq_set = '0;
        irq_set[IRQ_KEY_EVENT] = key_hit;
        irq_set[IRQ_WAKE_EVENT] = key_hit && key_irq_enable && wake_mode;
        irq_clr = '0;
        if (rd_fire && addr_is(paddr, OFS_IRQ_STATUS))
        begin
            irq_clr = '1;
        end
        next_irq_status = (irq_status & ~irq_clr) | irq_set;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            irq_status <= '0;
        end
        else if (ce)
        begin
            if (deep_stop)
            begin
                irq_status <= '0;
            end
            else
            begin
                irq_status <= next_irq_status;
            end
        end
    end

    // ***********************
    // request outputs
    // ***********************
    // all registered, so each follows its cause by one cycle
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            key_request <= 1'b0;
            wake_request <= 1'b0;
            irq <= 1'b0;
        end
        else if (ce)
        begin
            key_request <= event_flag && key_irq_enable && !deep_stop;
            wake_request <= event_flag && key_irq_enable && wake_mode;
            irq <= |(irq_status & irq_mask);
        end
    end

endmodule

// ### src/key_wake_pkg.sv
// constants, register map and mode encoding for the key wake unit
// assumes a 32-bit apb bus and a power-mode code from the system controller
package key_wake_pkg;

    // ***********************
    // sizes
    // ***********************
    localparam int KEY_PINS = 8;
    localparam int APB_ADDR_W = 12;
    localparam int APB_DATA_W = 32;

    // ***********************
    // register byte offsets
    // ***********************
    localparam logic [11:0] OFS_STATUS_CTRL = 12'h000;
    localparam logic [11:0] OFS_PIN_ENABLE = 12'h004;
    localparam logic [11:0] OFS_EDGE_SELECT = 12'h008;
    localparam logic [11:0] OFS_IRQ_STATUS = 12'h00C;
    localparam logic [11:0] OFS_IRQ_MASK = 12'h010;

    // ***********************
    // status and control fields
    // ***********************
    localparam int SC_LEVEL_MODE = 0;
    localparam int SC_IRQ_ENABLE = 1;
    localparam int SC_ACK = 2;
    localparam int SC_FLAG = 3;

    // ***********************
    // interrupt status fields
    // ***********************
    localparam int IRQ_BITS = 2;
    localparam int IRQ_KEY_EVENT = 0;
    localparam int IRQ_WAKE_EVENT = 1;

    // ***********************
    // reset values
    // ***********************
    localparam logic [7:0] RST_PIN_ENABLE = 8'h00;
    localparam logic [7:0] RST_EDGE_SELECT = 8'h00;
    localparam logic [1:0] RST_IRQ_MASK = 2'h0;

    // ***********************
    // power modes
    // ***********************
    typedef enum logic [2:0] {
        MODE_RUN = 3'b000,
        MODE_WAIT = 3'b001,
        MODE_STOP3 = 3'b010,
        MODE_STOP2 = 3'b011,
        MODE_STOP1 = 3'b100,
        MODE_BDM = 3'b101
    } power_mode_t;

endpackage

// ### tb/key_wake_monitor.sv
// port checker for the key wake unit
// assumes one clock domain and the one-wait-state apb answer
`timescale 1ns/1ps
module key_wake_monitor
    import key_wake_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // watched ports
    input wire key_wake_pkg::power_mode_t power_mode,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [key_wake_pkg::APB_DATA_W-1:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic key_request,
    input wire logic wake_request,
    input wire logic irq
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    logic acc;
    logic stop12;
    assign acc = psel && penable && pready;
    assign stop12 = power_mode == MODE_STOP1 || power_mode == MODE_STOP2;

    // *******************
    // bus and requests
    // *******************
    pready_wait_a: assert property ($rose(psel && penable) |-> !pready ##1 pready)
        else $error("pready not after one wait state");
    pready_pulse_a: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    slverr_ready_a: assert property (pslverr |-> pready && psel && penable)
        else $error("pslverr outside a completing access");
    bad_read_a: assert property (pslverr && !pwrite |-> prdata == 32'h0)
        else $error("unmapped read data not zero");
    read_upper_a: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
        else $error("read data above bit 7 not zero");
    wake_mode_a: assert property (wake_request |-> key_request &&
        ($past(power_mode) == MODE_WAIT || $past(power_mode) == MODE_STOP3))
        else $error("wake request outside wait or stop3");
    stop_quiet_a: assert property (stop12 [*3] |-> !key_request && !wake_request && !irq)
        else $error("activity in stop1 or stop2");
    req_fall_a: assert property ($fell(key_request) |-> $past(acc && pwrite) ||
        $past(acc && pwrite, 2) || $past(stop12) || $past(stop12, 2))
        else $error("key request dropped without write");
    irq_fall_a: assert property ($fell(irq) |-> $past(acc) || $past(acc, 2) ||
        $past(stop12) || $past(stop12, 2))
        else $error("irq dropped without access");
    cover property (wake_request);
    cover property ($fell(irq));
    cover property (pslverr);
endmodule

// ### tb/key_pad.sv
// key pad model: switches on the key pins
// assumes the bench sets the wanted levels; pins move asynchronously
`timescale 1ns/1ps
module key_pad (
    // wanted levels
    input wire logic [7:0] level,
    // pins
    output logic [7:0] key_input_pin
);
    // delay keeps changes clear of the clock edge, like a real switch
    initial key_input_pin = 8'hFF;
    always @(level) key_input_pin <= #1.7 level;
endmodule

// ### tb/tb_key_wake_unit.sv
// self-checking bench for the key wake unit
// assumes key_pad.sv and key_wake_monitor.sv compiled before it
`timescale 1ns/1ps
module tb_key_wake_unit;
    import key_wake_pkg::*;
    logic clk = 1'h0;
    logic rst_n = 1'h0;
    power_mode_t power_mode = MODE_RUN;
    logic [7:0] level = 8'hFF;
    logic [7:0] pins;
    logic psel = 1'h0;
    logic penable = 1'h0;
    logic pwrite = 1'h0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, key_request, wake_request, irq, err;
    logic [31:0] rd;
    logic [31:0] rnd = 32'h000130B7;
    logic [11:0] offs [5] = '{OFS_STATUS_CTRL, OFS_PIN_ENABLE, OFS_EDGE_SELECT,
        OFS_IRQ_STATUS, OFS_IRQ_MASK};
    power_mode_t modes [6] = '{MODE_WAIT, MODE_STOP3, MODE_BDM, MODE_STOP2, MODE_STOP1,
        MODE_RUN};
    int n_fail = 0;
    int check_count = 0;
    int cyc = 0;

    key_pad PAD (.level(level), .key_input_pin(pins));
    key_wake_unit DUT (.clk(clk), .rst_n(rst_n), .ce(1'h1), .power_mode(power_mode),
        .key_input_pin(pins), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .key_request(key_request), .wake_request(wake_request),
        .irq(irq));

    initial
    begin
        forever #2.5 clk = ~clk;
    end

    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            n_fail++;
            end_sim();
        end
    end

    // *******************
    // helpers
    // *******************
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic exp_key(input power_mode_t m);
        return m != MODE_STOP1 && m != MODE_STOP2;
    endfunction
    function automatic logic exp_wake(input power_mode_t m);
        return m == MODE_WAIT || m == MODE_STOP3;
    endfunction
    task automatic end_sim();
        if (n_fail == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp)
        begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] data);
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= data;
        @(posedge clk);
        penable <= 1'h1;
        // no cycle limit here: a slave that never answers runs into the bench timeout
        do
        begin
            @(posedge clk);
        end
        while (pready !== 1'h1);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge clk);
    endtask
    // pins go inactive first; the status read drops bits left by the change
    task automatic setup(input logic [7:0] en, input logic [7:0] sel, input logic [31:0] sc);
        level <= ~sel;
        apb(1'h1, OFS_PIN_ENABLE, 32'(en));
        apb(1'h1, OFS_EDGE_SELECT, 32'(sel));
        apb(1'h1, OFS_STATUS_CTRL, sc);
        apb(1'h0, OFS_IRQ_STATUS, 32'h0);
    endtask

    // *******************
    // main sequence
    // *******************
    initial
    begin
        repeat (20) @(posedge clk);
        rst_n <= 1'h1;
        @(posedge clk);
        foreach (offs[k])
        begin
            apb(1'h0, offs[k], 32'h0);
            chk("reset value", 32'h0, rd);
        end
        apb(1'h0, 12'h014, 32'h0);
        chk("unmapped read", 32'h1, {rd[30:0], err});
        for (int i = 0; i < KEY_PINS; i++)
        begin
            rnd = lfsr(rnd);
            apb(1'h1, OFS_IRQ_MASK, 32'(rnd[16]));
            setup(rnd[7:0], rnd[15:8], 32'h6);
            level[i] <= rnd[8 + i];
            repeat (8) @(posedge clk);
            chk("key request", 32'(rnd[i]), 32'(key_request));
            chk("irq", 32'(rnd[i] & rnd[16]), 32'(irq));
            apb(1'h0, OFS_IRQ_STATUS, 32'h0);
            chk("key status", 32'(rnd[i]), rd);
            apb(1'h1, OFS_STATUS_CTRL, 32'h6);
            apb(1'h0, OFS_STATUS_CTRL, 32'h0);
            chk("flag after ack", 32'h2, rd);
            chk("irq cleared", 32'h0, 32'(irq));
        end
        setup(8'h01, 8'h00, 32'h7);
        level[0] <= 1'h0;
        repeat (8) @(posedge clk);
        apb(1'h1, OFS_STATUS_CTRL, 32'h7);
        apb(1'h0, OFS_STATUS_CTRL, 32'h0);
        chk("level flag", 32'hB, rd);
        level[0] <= 1'h1;
        repeat (4) @(posedge clk);
        apb(1'h1, OFS_STATUS_CTRL, 32'h7);
        apb(1'h0, OFS_STATUS_CTRL, 32'h0);
        chk("level released", 32'h3, rd);
        foreach (modes[k])
        begin
            setup(8'h01, 8'h00, 32'h6);
            power_mode <= modes[k];
            @(posedge clk);
            level[0] <= 1'h0;
            repeat (8) @(posedge clk);
            chk("mode key", 32'(exp_key(modes[k])), 32'(key_request));
            chk("mode wake", 32'(exp_wake(modes[k])), 32'(wake_request));
            power_mode <= MODE_RUN;
            @(posedge clk);
            apb(1'h0, OFS_PIN_ENABLE, 32'h0);
            chk("enable after mode", 32'(exp_key(modes[k])), rd);
            // the wake bit is only set by a hit in wait or stop3; stop1/2 leave nothing
            apb(1'h0, OFS_IRQ_STATUS, 32'h0);
            chk("mode status", 32'({exp_wake(modes[k]), exp_key(modes[k])}), rd);
        end
        end_sim();
    end
endmodule

bind key_wake_unit key_wake_monitor MON (.clk(clk), .rst_n(rst_n),
    .power_mode(power_mode), .psel(psel), .penable(penable), .pwrite(pwrite),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .key_request(key_request),
    .wake_request(wake_request), .irq(irq));
